/* design/ursd_receiver.sv */
// design: uart receiver with majority sampling, early start and start frame detect
//
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
module ursd_receiver #(
    parameter int DIV_WIDTH = 16
) (
    // clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // serial line and power hooks
    input wire logic serial_receive_input,
    input wire logic sleeping,
    output logic osc_power_up,
    output logic port_clock_enable,
    output logic receive_start_irq,
    output logic frame_valid
);
    import ursd_pkg::*;

    // registers
    logic [7:0] ctrl;
    logic [DIV_WIDTH-1:0] baud_divisor;
    logic [9:0] rx_data;
    logic frame_error_flag;
    logic data_valid;
    logic start_seen;
    // ahb address phase capture
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr_q;
    // receiver state
    ursd_state_type state;
    logic [DIV_WIDTH-1:0] div_cnt;
    logic [3:0] samp_cnt;
    logic [3:0] bit_cnt;
    logic [9:0] shift;
    logic [2:0] votes;
    logic rx_prev;

    // control fields
    wire logic rx_enable = ctrl[CTRL_RX_EN_BIT];
    wire logic double_speed_select = ctrl[CTRL_DOUBLE_SPEED_BIT];
    wire logic start_frame_detect_enable = ctrl[CTRL_SFD_EN_BIT];
    wire logic receive_start_irq_enable = ctrl[CTRL_START_IRQ_EN_BIT];
    wire logic [3:0] size_raw = ctrl[CTRL_SIZE_MSB:CTRL_SIZE_LSB];

    // clamp frame length into supported range
    wire logic [3:0] data_bits = (size_raw < MIN_DATA_BITS) ? MIN_DATA_BITS :
        (size_raw > MAX_DATA_BITS) ? MAX_DATA_BITS : size_raw;

    // sampling geometry per speed mode
    wire logic [3:0] last_sample = double_speed_select ? SAMPLES_DOUBLE : SAMPLES_NORMAL;
    wire logic [3:0] first_vote = double_speed_select ? FIRST_VOTE_DOUBLE : FIRST_VOTE_NORMAL;
    wire logic [3:0] mid_vote = double_speed_select ? MID_VOTE_DOUBLE : MID_VOTE_NORMAL;
    wire logic [3:0] last_vote = mid_vote + 4'h1;

    // majority of three samples
    function automatic logic majority(input logic [2:0] s);
        majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction : majority

    // sample tick and vote window
    wire logic tick = clk_en && (div_cnt == baud_divisor);
    wire logic in_vote = (samp_cnt >= first_vote) && (samp_cnt <= last_vote);
    wire logic vote_done = tick && (samp_cnt == last_vote);
    wire logic bit_end = tick && (samp_cnt == last_sample);
    wire logic [2:0] votes_now = {votes[1:0], serial_receive_input};
    wire logic voted_bit = majority(votes_now);
    wire logic fall_edge = rx_prev && !serial_receive_input;
    // start frame detect: falling edge while enabled
    wire logic sfd_hit = start_frame_detect_enable && rx_enable && fall_edge
        && state == ST_IDLE;

    // ahb decode
    wire logic bus_go = hsel && hready && htrans[1];
    wire logic rd_data_hit = rd_pend && addr_q == DATA_OFFSET;
    // read word chosen in the address phase so hrdata stands through the data phase
    wire logic [7:0] rd_addr = {haddr[7:2], 2'b00};
    wire logic [31:0] read_mux =
        (rd_addr == CTRL_OFFSET) ? {24'h000000, ctrl} :
        (rd_addr == BAUD_OFFSET) ? {{(32-DIV_WIDTH){1'b0}}, baud_divisor} :
        (rd_addr == STATUS_OFFSET) ? {27'h0000000, osc_power_up, start_seen,
            state != ST_IDLE, frame_error_flag, data_valid} :
        (rd_addr == DATA_OFFSET) ? {22'h000000, rx_data} : 32'h00000000;

    // ahb address phase capture; always zero wait, okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            addr_q <= 8'h00;
        end else if (clk_en) begin
            wr_pend <= bus_go && hwrite;
            rd_pend <= bus_go && !hwrite;
            if (bus_go) begin
                addr_q <= {haddr[7:2], 2'b00};
            end
        end
    end

    // registered bus outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
        end else if (clk_en) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= (bus_go && !hwrite) ? read_mux : hrdata;
        end
    end

    // software registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= CTRL_RESET;
            baud_divisor <= DIV_WIDTH'(BAUD_RESET);
        end else if (clk_en && wr_pend) begin
            if (addr_q == CTRL_OFFSET) begin
                ctrl <= hwdata[7:0];
            end
            if (addr_q == BAUD_OFFSET) begin
                baud_divisor <= hwdata[DIV_WIDTH-1:0];
            end
        end
    end

    // sample divider, restarted by a start edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt <= '0;
            rx_prev <= 1'b1;
        end else if (clk_en) begin
            rx_prev <= serial_receive_input;
            if (state == ST_IDLE || tick) begin
                div_cnt <= '0;
            end else begin
                div_cnt <= div_cnt + 1'b1;
            end
        end
    end

    // receive state machine
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_IDLE;
            samp_cnt <= 4'h0;
            bit_cnt <= 4'h0;
            shift <= 10'h000;
            votes <= 3'b000;
        end else if (clk_en) begin
            if (!rx_enable) begin
                state <= ST_IDLE;
            end else begin
                unique case (state)
                    ST_IDLE: begin
                        // falling edge: sample 1 is the first low sample
                        if (fall_edge) begin
                            state <= ST_START;
                            samp_cnt <= 4'h1;
                            bit_cnt <= 4'h0;
                        end
                    end
                    ST_START, ST_DATA, ST_STOP: begin
                        if (tick) begin
                            samp_cnt <= (samp_cnt == last_sample) ? 4'h0 : samp_cnt + 4'h1;
                            if (in_vote) begin
                                votes <= votes_now;
                            end
                        end
                        if (vote_done && state == ST_START && !voted_bit) begin
                            state <= ST_DATA;
                        end else if (vote_done && state == ST_START) begin
                            state <= ST_IDLE; // noise spike rejected
                        end else if (vote_done && state == ST_DATA) begin
                            shift <= {voted_bit, shift[9:1]};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (vote_done && state == ST_STOP) begin
                            state <= ST_IDLE;
                        end
                        if (bit_end && state == ST_DATA && bit_cnt == data_bits) begin
                            state <= ST_STOP;
                        end
                    end
                endcase
            end
        end
    end

    // character and its frame error captured together
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_data <= 10'h000;
            frame_error_flag <= 1'b0;
            data_valid <= 1'b0;
            frame_valid <= 1'b0;
        end else if (clk_en) begin
            frame_valid <= vote_done && state == ST_STOP;
            if (vote_done && state == ST_STOP) begin
                rx_data <= shift >> (4'hA - data_bits);
                frame_error_flag <= !voted_bit;
                data_valid <= 1'b1; // set wins over the read
            end else if (rd_data_hit) begin
                data_valid <= 1'b0;
            end
        end
    end

    // start frame detect, wake and start interrupt
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_power_up <= 1'b0;
            port_clock_enable <= 1'b0;
            receive_start_irq <= 1'b0;
            start_seen <= 1'b0;
        end else if (clk_en) begin
            receive_start_irq <= sfd_hit && receive_start_irq_enable;
            if (sfd_hit && sleeping) begin
                osc_power_up <= 1'b1;
                port_clock_enable <= 1'b1;
            end else if (frame_valid || !sleeping || state == ST_IDLE && !osc_power_up) begin
                osc_power_up <= 1'b0;
                port_clock_enable <= 1'b0;
            end
            if (sfd_hit) begin
                start_seen <= 1'b1;
            end else if (wr_pend && addr_q == STATUS_OFFSET) begin
                start_seen <= 1'b0;
            end
        end
    end

    // frame error follows the stop vote of the same frame
    a_stop_error: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && vote_done && state == ST_STOP |=> frame_error_flag == !$past(voted_bit))
        else $error("frame error not from stop vote");
    // after stop votes the receiver is idle again
    a_early_start: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && rx_enable && vote_done && state == ST_STOP |=> state == ST_IDLE)
        else $error("early start not enabled");
    // sample counter stays in its range
    a_sample_range: assert property (@(posedge hclk) disable iff (!hresetn)
        state != ST_IDLE |-> samp_cnt <= last_sample)
        else $error("sample counter out of range");
    // vote window starts at the first sample number
    a_vote_first: assert property (@(posedge hclk) disable iff (!hresetn)
        in_vote |-> samp_cnt >= (double_speed_select ? 4'h4 : 4'h8))
        else $error("vote before first sample");
    // vote decided one past middle sample
    a_vote_mid: assert property (@(posedge hclk) disable iff (!hresetn)
        vote_done |-> samp_cnt == (double_speed_select ? 4'h6 : 4'hA))
        else $error("vote end misplaced");
    // data bit count never exceeds limit
    a_bits_range: assert property (@(posedge hclk) disable iff (!hresetn)
        state == ST_DATA |-> bit_cnt <= 4'hA)
        else $error("too many data bits");
    // no wake without enable
    a_sfd_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(osc_power_up) |-> $past(start_frame_detect_enable))
        else $error("wake without detect enable");
    // start interrupt one cycle after detect
    a_start_irq: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && sfd_hit && receive_start_irq_enable |=> receive_start_irq)
        else $error("start interrupt missing");
    // every bus answer is okay with no wait state
    a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
        hreadyout && !hresp)
        else $error("bus answer not okay zero wait");
    // stop vote of a frame, shared by the stored-pulse and oscillator-release checks
    sequence s_stop_vote;
        clk_en && vote_done && state == ST_STOP;
    endsequence
    // start edge seen while the device sleeps
    sequence s_wake_edge;
        clk_en && sfd_hit && sleeping;
    endsequence
    // character stored pulse lasts one cycle
    a_valid_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
        s_stop_vote |=> frame_valid ##1 !frame_valid)
        else $error("stored pulse not one cycle");
    // data bit shifted in is the majority vote
    a_majority_bit: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && vote_done && state == ST_DATA |=> shift[9] == $past(voted_bit))
        else $error("data bit not the majority");
    // a start bit voted high is dropped as noise
    a_start_reject: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && rx_enable && vote_done && state == ST_START && voted_bit |=> state == ST_IDLE)
        else $error("noisy start not rejected");
    // speed select picks the samples per bit
    a_speed_samples: assert property (@(posedge hclk) disable iff (!hresetn)
        last_sample == (double_speed_select ? 4'h7 : 4'hF))
        else $error("samples per bit wrong for speed");
    // frame error changes only at a stop vote
    a_error_kept: assert property (@(posedge hclk) disable iff (!hresetn)
        !(clk_en && vote_done && state == ST_STOP) |=> $stable(frame_error_flag))
        else $error("frame error changed between frames");
    // no start detect while detection is off
    a_sfd_off: assert property (@(posedge hclk) disable iff (!hresetn)
        !start_frame_detect_enable |-> !sfd_hit)
        else $error("start detect while disabled");
    // a start edge in sleep requests the oscillator
    a_wake_on: assert property (@(posedge hclk) disable iff (!hresetn)
        s_wake_edge |=> osc_power_up)
        else $error("no wake on start edge");
    // port clock follows the oscillator request
    a_port_clock: assert property (@(posedge hclk) disable iff (!hresetn)
        port_clock_enable == osc_power_up)
        else $error("port clock apart from oscillator");
    // oscillator released once the character is stored
    a_wake_off: assert property (@(posedge hclk) disable iff (!hresetn)
        s_stop_vote ##1 (frame_valid && !(sfd_hit && sleeping)) |=> !osc_power_up)
        else $error("oscillator kept after frame");
    // reading the data word clears valid unless a frame lands
    a_read_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && rd_data_hit && !(vote_done && state == ST_STOP) |=> !data_valid)
        else $error("data read left valid set");
endmodule : ursd_receiver

/* pkg/ursd_pkg.sv */
// package: register map, field layout, resets and frame constants for the uart receiver
package ursd_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] BAUD_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;
    localparam logic [7:0] DATA_OFFSET = 8'h0C;
    // control field positions
    localparam int CTRL_RX_EN_BIT = 0;
    localparam int CTRL_DOUBLE_SPEED_BIT = 1;
    localparam int CTRL_SFD_EN_BIT = 2;
    localparam int CTRL_START_IRQ_EN_BIT = 3;
    localparam int CTRL_SIZE_LSB = 4;
    localparam int CTRL_SIZE_MSB = 7;
    // status field positions
    localparam int STATUS_VALID_BIT = 0;
    localparam int STATUS_FRAME_ERR_BIT = 1;
    localparam int STATUS_BUSY_BIT = 2;
    localparam int STATUS_START_SEEN_BIT = 3;
    localparam int STATUS_WAKE_BIT = 4;
    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h81;
    localparam logic [15:0] BAUD_RESET = 16'h0000;
    // samples per bit and voting sample numbers
    localparam logic [3:0] SAMPLES_NORMAL = 4'hF;
    localparam logic [3:0] SAMPLES_DOUBLE = 4'h7;
    localparam logic [3:0] FIRST_VOTE_NORMAL = 4'h8;
    localparam logic [3:0] FIRST_VOTE_DOUBLE = 4'h4;
    localparam logic [3:0] MID_VOTE_NORMAL = 4'h9;
    localparam logic [3:0] MID_VOTE_DOUBLE = 4'h5;
    // frame data length limits
    localparam logic [3:0] MIN_DATA_BITS = 4'h5;
    localparam logic [3:0] MAX_DATA_BITS = 4'hA;
    // receive state codes
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_START = 2'b01,
        ST_DATA = 2'b10,
        ST_STOP = 2'b11
    } ursd_state_type;
endpackage : ursd_pkg

/* verification/ursd_serial_tx.sv */
// partner model: remote serial transmitter driving the receive line
`timescale 1ns/1ns
module ursd_serial_tx (
    // clock
    input wire logic hclk,
    // serial line, idle high
    output logic line
);
    initial line = 1'h1;
    // hold the line at one level for n clock cycles
    task automatic hold(input logic v, input int n);
        line <= v;
        repeat (n) @(posedge hclk);
    endtask : hold
    // one frame, lsb first; sp picks a bit that carries a short mid-bit spike
    // rates used stay inside the sleep wake limits
    task automatic send(input logic [9:0] d, input int nb, input int bc, input logic sb,
                        input int sl, input int sp);
        @(posedge hclk);
        hold(1'h0, bc); // bit length set by caller inside the rate window
        for (int i = 0; i < nb; i++) begin
            if (i == sp) begin
                hold(d[i], bc / 2);
                hold(~d[i], bc / 16);
                hold(d[i], bc - bc / 2 - bc / 16);
            end else begin
                hold(d[i], bc);
            end
        end
        hold(sb, sl);
        line <= 1'h1;
    endtask : send
endmodule : ursd_serial_tx

/* verification/uart_rx_stop_and_start_detect_test.sv */
// testbench: voting, frame error, early start and start frame detect of the receiver
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED at %0t got %h exp %h", $time, (g), (e)); end end
module uart_rx_stop_and_start_detect_test;
    import ursd_pkg::*;
    logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, sleeping = 1'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, rx_line, osc_power_up, port_clock_enable, receive_start_irq;
    logic frame_valid;
    int n_mismatch = 0, checks_done = 0, cycles = 0;
    // clock and hang guard
    always #5 hclk = ~hclk;
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 60000) begin
            n_mismatch++;
            results();
        end
    end
    ursd_serial_tx u_ursd_serial_tx (.hclk(hclk), .line(rx_line));
    ursd_receiver u_ursd_receiver (.hclk(hclk), .hresetn(hresetn), .clk_en(1'h1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .serial_receive_input(rx_line), .sleeping(sleeping),
        .osc_power_up(osc_power_up), .port_clock_enable(port_clock_enable),
        .receive_start_irq(receive_start_irq), .frame_valid(frame_valid));
    // one single ahb-lite word transfer; read data lands in rd
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'h1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hsel <= 1'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rd = hrdata;
    endtask : bus
    // wait a bounded time for the character-stored pulse
    task automatic wait_valid();
        for (int i = 0; i < 2000 && frame_valid !== 1'h1; i++) @(posedge hclk);
        `CHK(frame_valid, 1'h1)
    endtask : wait_valid
    // send one frame, then check the stored character and its frame error flag
    task automatic frame(input logic [7:0] c, input logic [9:0] d, input int nb, input int bc,
                         input logic sb, input int sp);
        bus(1'h1, CTRL_OFFSET, {24'h0, c});
        fork
            u_ursd_serial_tx.send(d, nb, bc, sb, bc, sp);
            wait_valid();
        join
        bus(1'h0, STATUS_OFFSET, 32'h0);
        `CHK(rd[STATUS_FRAME_ERR_BIT], ~sb)
        bus(1'h0, DATA_OFFSET, 32'h0);
        `CHK(rd, {22'h0, d} & ((32'h1 << nb) - 32'h1))
    endtask : frame
    // reset value, unmapped place, baud divisor of four clocks per sample
    task automatic sc_regs();
        bus(1'h0, CTRL_OFFSET, 32'h0);
        `CHK(rd, 32'h81)
        bus(1'h1, 8'h10, 32'hFFFF);
        bus(1'h0, 8'h10, 32'h0);
        `CHK(rd, 32'h0)
        bus(1'h1, BAUD_OFFSET, 32'h3);
        bus(1'h0, BAUD_OFFSET, 32'h0);
        `CHK(rd, 32'h3)
    endtask : sc_regs
    // majority voting with a one-sample spike, both speeds, bad stop bit
    task automatic sc_vote();
        frame(8'h81, 10'hA5, 8, 64, 1'h1, 0);
        frame(8'h81, 10'h5A, 8, 64, 1'h1, 3);
        frame(8'h83, 10'h3C, 8, 32, 1'h1, 2);
        frame(8'h81, 10'h0F, 8, 64, 1'h0, -1);
        frame(8'h81, 10'hF0, 8, 64, 1'h1, -1);
    endtask : sc_vote
    // every frame length and rates near the edges of the window
    task automatic sc_range();
        for (int n = 5; n <= 10; n++) begin
            frame({4'(n), 4'h1}, 10'h2B5, n, 64, 1'h1, -1);
        end
        frame(8'h81, 10'h96, 8, 62, 1'h1, -1);
        frame(8'h81, 10'h69, 8, 66, 1'h1, -1);
        frame(8'h83, 10'hC3, 8, 31, 1'h1, -1);
        frame(8'h83, 10'h3C, 8, 33, 1'h1, -1);
    endtask : sc_range
    // next start bit right after the stop-bit votes
    task automatic sc_early();
        bus(1'h1, CTRL_OFFSET, 32'h81);
        fork
            begin
                u_ursd_serial_tx.send(10'h11, 8, 64, 1'h1, 44, -1);
                u_ursd_serial_tx.send(10'h22, 8, 64, 1'h1, 64, -1);
            end
            begin
                wait_valid();
                bus(1'h0, DATA_OFFSET, 32'h0);
                `CHK(rd, 32'h11)
                wait_valid();
                bus(1'h0, DATA_OFFSET, 32'h0);
                `CHK(rd, 32'h22)
            end
        join
    endtask : sc_early
    // start frame detect in sleep: with interrupt, without it, disabled
    task automatic sc_wake();
        logic seen_irq;
        logic seen_osc;
        sleeping <= 1'h1;
        for (int m = 0; m < 3; m++) begin
            bus(1'h1, CTRL_OFFSET, m == 0 ? 32'h8D : m == 1 ? 32'h85 : 32'h81);
            seen_irq = 1'h0;
            seen_osc = 1'h0;
            fork
                u_ursd_serial_tx.send(10'h77, 8, 64, 1'h1, 64, -1);
                repeat (40) begin
                    @(posedge hclk);
                    seen_irq = seen_irq | receive_start_irq;
                    seen_osc = seen_osc | osc_power_up;
                    `CHK(port_clock_enable, osc_power_up)
                end
            join
            `CHK(seen_irq, 1'(m == 0))
            `CHK(seen_osc, 1'(m < 2))
        end
        sleeping <= 1'h0;
    endtask : sc_wake
    // report counts and the verdict, then stop
    task automatic results();
        $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results
    // main sequence
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        sc_regs();
        sc_vote();
        sc_range();
        sc_early();
        sc_wake();
        results();
    end
endmodule : uart_rx_stop_and_start_detect_test
